// >>> usb_pkg.sv
// usb_pkg: constants for the uart sleep, time-out, break and baud block.
// assumes a 3-bit register address port and sys_clk acting as crystal clock.
package usb_pkg;
  // register addresses
  localparam logic [2:0] ADR_DATA  = 3'h0; // fifo data, or divisor low byte
  localparam logic [2:0] ADR_IER   = 3'h1; // interrupt enable, or divisor high
  localparam logic [2:0] ADR_EFR   = 3'h2; // enhanced features when lcr = key
  localparam logic [2:0] ADR_LCR   = 3'h3;
  localparam logic [2:0] ADR_MCR   = 3'h4;
  localparam logic [2:0] ADR_LSR   = 3'h5;
  localparam logic [2:0] ADR_STAT  = 3'h7; // block status
  localparam logic [7:0] LCR_EFKEY = 8'h_BF;
  // field positions
  localparam int LCR_DLAB  = 7;
  localparam int LCR_BRK   = 6;
  localparam int LCR_PAR   = 3;
  localparam int LCR_STOP  = 2;
  localparam int IER_SLEEP = 4;
  localparam int EFR_ENH   = 4;
  localparam int MCR_PRE   = 7;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h_1D;
  localparam logic [7:0] IER_RST = 8'h_00;
  localparam logic [7:0] MCR_RST = 8'h_00;
  localparam logic [7:0] EFR_RST = 8'h_00;
  // timing, in 16x baud ticks
  localparam int TICKS_PER_BIT = 16;
  localparam int TIMEOUT_CHARS = 4;
  localparam int PRESCALE_DIV  = 4;
  localparam logic [1:0] PRE_LAST = 2'h3;
  // generator test vectors
  localparam int XTAL_A_HZ = 1_843_200;
  localparam int BAUD_A    = 9600;
  localparam int DIV_A     = 12;
  localparam int XTAL_B_HZ = 3_072_000;
  localparam int BAUD_B    = 38400;
  localparam int DIV_B     = 5;
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } usb_state_t;
endpackage : usb_pkg

// >>> usb_top.sv
// usb_top: uart sleep control, receive time-out, break logic and baud generator.
// assumes the fifo, shifters and interrupt encoder sit outside on sys_clk.
// How it works
// - any of interrupt enable bits 3:0 set lets status drive the irq output.
// - with enable bits 3:0 all zero, no irq; host polls line status.
// - sleep allowed only with enhanced enable and sleep enable both set.
// - sleep needs idle rx, empty tx path, only thr pending, empty rx fifo.
// - asleep, the uart clock enable drops and baud logic halts.
// - rx transition, modem pin change or tx fifo write wakes the block.
// - time-out interrupt after four character times of stale rx data.
// - time-out counter restarts at stop bit centre and rx fifo read.
// - break flagged when rx stays low longer than one whole frame.
// - set-break bit holds tx low until software clears it.
// - baud generator divides by a 16-bit divisor, 1 to 65535.
// - prescaler divides by 4 when enabled, by 1 after reset.
// - generator output runs at sixteen times the bit rate.
// - divisor low byte is bits 7:0, high byte bits 15:8.
// - divisor of zero produces no baud ticks.
// - one baud tick drives both transmitter and receiver.
// - 1.8432 MHz, divide-by-1, divisor 12 gives 9600 baud.
// - 3.072 MHz, divide-by-1, divisor 5 gives 38400, 20 gives 9600.
// - divisor bytes reachable only while line control bit 7 is set.
// - prescaler bit writable only while enhanced enable is set.
// - reset leaves divisor bytes untouched.
`timescale 1ns/10ps
module usb_top
  import usb_pkg::*;
(
  input  wire logic       sys_clk,         // crystal clock
  input  wire logic       rst,             // async reset, active high
  input  wire logic [2:0] regAddr,         // register address
  input  wire logic [7:0] regWdata,        // write data
  input  wire logic       regWr,           // write strobe
  input  wire logic       regRd,           // read strobe
  output logic      [7:0] regRdata,        // read data, cycle after strobe
  input  wire logic       rxPin,           // serial input pin
  input  wire logic [3:0] modemPins,       // modem input pins
  input  wire logic       txData,          // serial data from transmitter
  output logic            txPin,           // serial output pin
  input  wire logic [3:0] intSrc,          // rx avail, thr, line stat, modem
  input  wire logic       intOtherPend,    // a non-thr interrupt pending
  input  wire logic       txFifoEmpty,     // tx fifo empty
  input  wire logic       txShiftEmpty,    // tx shift register empty
  input  wire logic       rxFifoEmpty,     // rx fifo empty
  input  wire logic       rxBelowTrig,     // rx fifo under trigger level
  input  wire logic       rxBusy,          // receiver inside a frame
  input  wire logic       stopCentre,      // pulse at centre of stop bit
  output logic            irqN,            // interrupt request, active low
  output logic            timeoutIrq,      // receive time-out pending
  output logic            breakDet,        // break on rx line
  output logic            baudTick,        // 16x tick to tx and rx
  output logic            uartClkEn,       // uart clock enable
  output logic            rxFifoRd,        // pulse: rx fifo read
  output logic            txFifoWr,        // pulse: tx fifo write
  output logic      [7:0] txFifoData       // data for tx fifo
);
  function automatic logic [9:0] char_ticks(input logic [7:0] line_control_reg);
    logic [9:0] bits;
    bits = 10'(6) + {8'h_00, line_control_reg[1:0]} + {9'h_000, line_control_reg[LCR_PAR]};
    if (!line_control_reg[LCR_STOP])
      return 10'(bits * TICKS_PER_BIT + TICKS_PER_BIT);
    else if (line_control_reg[1:0] == 2'b00)
      return 10'(bits * TICKS_PER_BIT + TICKS_PER_BIT * 3 / 2);
    else
      return 10'(bits * TICKS_PER_BIT + TICKS_PER_BIT * 2);
  endfunction : char_ticks

  logic [7:0]  ierReg_r, lcrReg_r, mcrReg_r, efrReg_r;
  logic [7:0]  divLo_r, divHi_r;
  logic [15:0] divisor;
  logic [1:0]  preCnt_r;
  logic [15:0] divCnt_r;
  logic        rxS1_r, rxS2_r, rxS3_r;
  logic [3:0]  mdS1_r, mdS2_r, mdS3_r;
  logic [9:0]  charTicks;
  logic [11:0] toCnt_r;
  logic [9:0]  brkCnt_r;
  usb_state_t  state_r, state_nxt;
  logic        sleepOk, wakeEv, asleep, dlab, efKey;
  logic        wrData, rdData;

  assign dlab   = lcrReg_r[LCR_DLAB];
  assign efKey  = (lcrReg_r == LCR_EFKEY);
  assign asleep = (state_r == ST_ASLEEP);
  assign wrData = regWr && regAddr == ADR_DATA && !dlab;
  assign rdData = regRd && regAddr == ADR_DATA && !dlab;
  assign rxFifoRd   = rdData;
  assign txFifoWr   = wrData;
  assign txFifoData = regWdata;
  assign divisor   = {divHi_r, divLo_r};
  assign charTicks = char_ticks(lcrReg_r);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
      rxS3_r <= 1'b1;
      mdS1_r <= 4'h_0;
      mdS2_r <= 4'h_0;
      mdS3_r <= 4'h_0;
    end else begin
      rxS1_r <= rxPin;
      rxS2_r <= rxS1_r;
      rxS3_r <= rxS2_r;
      mdS1_r <= modemPins;
      mdS2_r <= mdS1_r;
      mdS3_r <= mdS2_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ierReg_r <= IER_RST;
      lcrReg_r <= LCR_RST;
      mcrReg_r <= MCR_RST;
      efrReg_r <= EFR_RST;
    end else if (regWr) begin
      if (regAddr == ADR_IER && !dlab)
        ierReg_r <= regWdata;
      if (regAddr == ADR_LCR)
        lcrReg_r <= regWdata;
      if (regAddr == ADR_EFR && efKey)
        efrReg_r <= regWdata;
      if (regAddr == ADR_MCR) begin
        mcrReg_r[6:0] <= regWdata[6:0];
        if (efrReg_r[EFR_ENH])
          mcrReg_r[MCR_PRE] <= regWdata[MCR_PRE];
      end
    end
  end

  // divisor has no reset; latch access bit gates it
  always_ff @(posedge sys_clk) begin
    if (regWr && dlab && regAddr == ADR_DATA)
      divLo_r <= regWdata;
    if (regWr && dlab && regAddr == ADR_IER)
      divHi_r <= regWdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h_00;
    end else if (regRd) begin
      case (regAddr)
        ADR_DATA: regRdata <= dlab ? divLo_r : 8'h_00;
        ADR_IER:  regRdata <= dlab ? divHi_r : ierReg_r;
        ADR_EFR:  regRdata <= efKey ? efrReg_r : 8'h_00;
        ADR_LCR:  regRdata <= lcrReg_r;
        ADR_MCR:  regRdata <= mcrReg_r;
        ADR_LSR:  regRdata <= {1'b0, txFifoEmpty & txShiftEmpty, txFifoEmpty,
                               breakDet, 3'b000, !rxFifoEmpty};
        ADR_STAT: regRdata <= {5'h_00, timeoutIrq, breakDet, asleep};
        default:  regRdata <= 8'h_00;
      endcase
    end
  end

  assign sleepOk = efrReg_r[EFR_ENH] && ierReg_r[IER_SLEEP] && rxS2_r && !rxBusy
                   && txFifoEmpty && txShiftEmpty && !intOtherPend && rxFifoEmpty
                   && !timeoutIrq;
  assign wakeEv  = (rxS2_r != rxS3_r) || (mdS2_r != mdS3_r) || wrData;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_AWAKE:  if (sleepOk && !wakeEv) state_nxt = ST_ASLEEP;
      ST_ASLEEP: if (wakeEv || !sleepOk) state_nxt = ST_AWAKE;
      default:   state_nxt = ST_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      state_r <= ST_AWAKE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      uartClkEn <= 1'b1;
    else
      uartClkEn <= (state_nxt == ST_AWAKE);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      preCnt_r <= 2'h0;
    else if (!mcrReg_r[MCR_PRE] || preCnt_r == PRE_LAST)
      preCnt_r <= 2'h0;
    else
      preCnt_r <= preCnt_r + 2'h1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 16'h_0000;
      baudTick <= 1'b0;
    end else if (asleep || divisor == 16'h_0000) begin
      divCnt_r <= 16'h_0000;
      baudTick <= 1'b0;
    end else if (mcrReg_r[MCR_PRE] && preCnt_r != PRE_LAST) begin
      baudTick <= 1'b0;
    // counts up against the divisor: the divisor bytes have no reset, so a
    // down-counter loaded from them could start unknown; a smaller new
    // divisor also takes effect at once instead of after a stale count
    end else if (divCnt_r + 16'h_0001 >= divisor) begin
      divCnt_r <= 16'h_0000;
      baudTick <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 16'h_0001;
      baudTick <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toCnt_r    <= 12'h_000;
      timeoutIrq <= 1'b0;
    end else if (stopCentre || rdData || rxFifoEmpty || !rxBelowTrig) begin
      toCnt_r    <= 12'h_000;
      timeoutIrq <= 1'b0;
    end else if (baudTick && !timeoutIrq) begin
      if (toCnt_r + 12'h_001 >= 12'(charTicks * TIMEOUT_CHARS))
        timeoutIrq <= 1'b1;
      toCnt_r <= toCnt_r + 12'h_001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      brkCnt_r <= 10'h_000;
      breakDet <= 1'b0;
    end else if (rxS2_r) begin
      brkCnt_r <= 10'h_000;
      breakDet <= 1'b0;
    end else if (baudTick && !breakDet) begin
      if (brkCnt_r >= charTicks)
        breakDet <= 1'b1;
      brkCnt_r <= brkCnt_r + 10'h_001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      txPin <= 1'b1;
    else
      txPin <= lcrReg_r[LCR_BRK] ? 1'b0 : txData;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      irqN <= 1'b1;
    else
      irqN <= !(|(ierReg_r[3:0] & intSrc) || (ierReg_r[0] && timeoutIrq));
  end

  sequence s_prog_fast;
    divisor == 16'h_0001 && !mcrReg_r[MCR_PRE] && !asleep;
  endsequence
  sequence s_mcr_locked_wr;
    regWr && regAddr == ADR_MCR && !efrReg_r[EFR_ENH];
  endsequence
  // rx held low for a whole frame, at a tick
  sequence s_rx_low_full;
    !rxS2_r && baudTick && brkCnt_r >= charTicks;
  endsequence

  a_irq_polled: assert property (@(posedge sys_clk) disable iff (rst)
    ierReg_r[3:0] == 4'h_0 && !$past(|ierReg_r[3:0]) |=> irqN)
    else $error("irq raised in polled mode");
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (rst)
    |(ierReg_r[3:0] & intSrc) |=> !irqN)
    else $error("enabled source did not raise irq");
  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(asleep) |-> $past(sleepOk))
    else $error("sleep entered without conditions");
  a_sleep_halt: assert property (@(posedge sys_clk) disable iff (rst)
    asleep |-> !uartClkEn ##1 !baudTick)
    else $error("clock running while asleep");
  a_wake_event: assert property (@(posedge sys_clk) disable iff (rst)
    asleep && wakeEv |=> !asleep ##0 uartClkEn)
    else $error("wake event ignored");
  a_break_hold: assert property (@(posedge sys_clk) disable iff (rst)
    lcrReg_r[LCR_BRK] [*2] |-> !txPin)
    else $error("tx not held low during break");
  a_div_zero: assert property (@(posedge sys_clk) disable iff (rst)
    divisor == 16'h_0000 |=> !baudTick)
    else $error("tick with zero divisor");
  a_div_one: assert property (@(posedge sys_clk) disable iff (rst)
    s_prog_fast ##1 s_prog_fast ##1 s_prog_fast |-> baudTick)
    else $error("divisor one does not tick each cycle");
  a_timeout_rst: assert property (@(posedge sys_clk) disable iff (rst)
    stopCentre || rdData |=> toCnt_r == 12'h_000 && !timeoutIrq)
    else $error("time-out counter not restarted");
  a_mcr_lock: assert property (@(posedge sys_clk) disable iff (rst)
    s_mcr_locked_wr |=> $stable(mcrReg_r[MCR_PRE]))
    else $error("prescaler changed while locked");
  a_break_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rxS2_r |=> !breakDet)
    else $error("break stuck with rx high");
  a_break_set: assert property (@(posedge sys_clk) disable iff (rst)
    s_rx_low_full ##0 !breakDet |=> breakDet)
    else $error("break not flagged after a full frame");

  // transmit path checks
  a_tx_follow: assert property (@(posedge sys_clk) disable iff (rst)
    !lcrReg_r[LCR_BRK] |=> txPin == $past(txData))
    else $error("tx pin does not follow transmitter");

  // baud generator shape
  a_tick_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && divisor > 16'h_0001 |=> !baudTick)
    else $error("tick wider than one cycle");
  a_prescale_gap: assert property (@(posedge sys_clk) disable iff (rst)
    mcrReg_r[MCR_PRE] && preCnt_r != PRE_LAST |=> !baudTick)
    else $error("tick outside prescaler slot");

  // time-out and interrupt checks
  a_timeout_empty: assert property (@(posedge sys_clk) disable iff (rst)
    rxFifoEmpty |=> !timeoutIrq)
    else $error("time-out with empty rx fifo");
  a_irq_timeout: assert property (@(posedge sys_clk) disable iff (rst)
    ierReg_r[0] && timeoutIrq |=> !irqN)
    else $error("time-out did not raise irq");

  // register access gating
  a_rd_div_hidden: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == ADR_DATA && !dlab |=> regRdata == 8'h_00)
    else $error("divisor visible without latch access");
  a_efr_lock: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADR_EFR && !efKey |=> $stable(efrReg_r))
    else $error("enhanced register written without key");

  // sleep checks
  a_sleep_fifo: assert property (@(posedge sys_clk) disable iff (rst)
    !rxFifoEmpty && !asleep |=> !asleep)
    else $error("sleep entered with rx data");
  a_sleep_off: assert property (@(posedge sys_clk) disable iff (rst)
    !ierReg_r[IER_SLEEP] |=> !asleep)
    else $error("asleep with sleep disabled");
  a_awake_clk: assert property (@(posedge sys_clk) disable iff (rst)
    !asleep |-> uartClkEn)
    else $error("clock stopped while awake");
  // a host write in the wake cycle may legally change a register
  a_wake_keep: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(asleep) && !$past(regWr) |-> $stable(ierReg_r) && $stable(lcrReg_r)
    && $stable(mcrReg_r))
    else $error("register changed on wake");
endmodule : usb_top

// >>> usb_far_end.sv
// usb_far_end: behavioural remote serial device and modem lines.
// assumes the bench calls its tasks between bus cycles on sys_clk.
`timescale 1ns/10ps
module usb_far_end (
  input  wire logic       sys_clk,    // bench clock
  input  wire logic       txPin,      // line from the block, watched only
  output logic            rxPin,      // line into the block
  output logic      [3:0] modemPins   // modem pins seen by the block
);
  // idle line is high; a stopped far end never leaves it floating
  initial begin
    rxPin     = 1'b1;
    modemPins = 4'h0;
  end
  task setLine(input logic lvl);
    @(posedge sys_clk);
    rxPin <= lvl;
  endtask : setLine
  task setModem(input logic [3:0] v);
    @(posedge sys_clk);
    modemPins <= v;
  endtask : setModem
endmodule : usb_far_end

// >>> tb_usb_top.sv
// tb_usb_top: register-level tests of sleep, time-out, break and baud logic.
// assumes sys_clk doubles as the crystal clock; divisor starts unknown.
`timescale 1ns/10ps
module tb_usb_top;
  import usb_pkg::*;
  logic       sys_clk, rst, regWr, regRd, txPin, irqN, timeoutIrq, breakDet;
  logic       baudTick, uartClkEn, rxFifoRd, txFifoWr, rxPin, stopCentre;
  logic       txFifoEmpty, rxFifoEmpty, rxBelowTrig;
  logic       txData, intOtherPend, txShiftEmpty, rxBusy;
  logic [7:0] lastTx;
  int         rdPulses = 0;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, txFifoData;
  logic [3:0] modemPins, intSrc;
  int         failures, tests_run, n;

  usb_top usb_top_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxPin(rxPin), .modemPins(modemPins),
    .txData(txData), .txPin(txPin), .intSrc(intSrc), .intOtherPend(intOtherPend),
    .txFifoEmpty(txFifoEmpty), .txShiftEmpty(txShiftEmpty), .rxFifoEmpty(rxFifoEmpty),
    .rxBelowTrig(rxBelowTrig), .rxBusy(rxBusy), .stopCentre(stopCentre), .irqN(irqN),
    .timeoutIrq(timeoutIrq), .breakDet(breakDet), .baudTick(baudTick),
    .uartClkEn(uartClkEn), .rxFifoRd(rxFifoRd), .txFifoWr(txFifoWr), .txFifoData(txFifoData));
  usb_far_end usb_far_end_i (.sys_clk(sys_clk), .txPin(txPin), .rxPin(rxPin),
    .modemPins(modemPins));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // fifo-side monitor: last byte pushed and number of fifo reads
  always @(posedge sys_clk) begin
    if (txFifoWr) lastTx <= txFifoData;
    if (rxFifoRd) rdPulses <= rdPulses + 1;
  end

  task tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask : rd
  // bounded wait; n gives the cycles taken, always at least one
  task automatic waitOn(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      #1;
      c++;
    end while (s !== v && c < lim);
    if (s !== v) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, v);
      tally_and_finish();
    end
  endtask : waitOn
  // first gap after a divisor change may be partial, so skip it
  task tickGap(input int e);
    waitOn(baudTick, 1'b1, 300, n);
    waitOn(baudTick, 1'b1, 300, n);
    waitOn(baudTick, 1'b1, 300, n);
    chk(n, e);
  endtask : tickGap
  task countTicks(input int cycles, output int c);
    c = 0;
    repeat (cycles) begin
      @(posedge sys_clk);
      #1;
      if (baudTick === 1'b1) c++;
    end
  endtask : countTicks
  task settle(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    {regWr, regRd, regAddr, regWdata, stopCentre, intSrc} = '0;
    {txFifoEmpty, rxFifoEmpty, rxBelowTrig} = 3'b111;
    {txData, intOtherPend, txShiftEmpty, rxBusy} = 4'b1010;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADR_LCR, LCR_RST);
    rd(ADR_IER, IER_RST);
    rd(ADR_MCR, MCR_RST);
    chk({txPin, irqN, uartClkEn}, 3'h7);
    $display("test reset values done");
    wr(ADR_LCR, 8'h80);
    wr(ADR_DATA, 8'h0C);
    wr(ADR_IER, 8'h00);
    rd(ADR_DATA, 8'h0C);
    wr(ADR_LCR, 8'h03);
    tickGap(DIV_A);
    @(posedge sys_clk);
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    wr(ADR_LCR, 8'h80);
    rd(ADR_DATA, 8'h0C);
    wr(ADR_DATA, 8'h05);
    wr(ADR_LCR, 8'h03);
    tickGap(DIV_B);
    wr(ADR_DATA, 8'h33);
    tickGap(DIV_B);
    wr(ADR_MCR, 8'h80);
    rd(ADR_MCR, 8'h00);
    wr(ADR_LCR, LCR_EFKEY);
    wr(ADR_EFR, 8'h10);
    wr(ADR_LCR, 8'h03);
    wr(ADR_MCR, 8'h80);
    tickGap(PRESCALE_DIV * DIV_B);
    wr(ADR_MCR, 8'h00);
    wr(ADR_LCR, 8'h80);
    wr(ADR_DATA, 8'h00);
    wr(ADR_IER, 8'h01);
    tickGap(256);
    wr(ADR_IER, 8'h00);
    countTicks(300, n);
    chk(n, 0);
    wr(ADR_DATA, 8'h01);
    wr(ADR_LCR, 8'h03);
    $display("test baud generator done");
    txData <= 1'b0;
    settle(3);
    chk(txPin, 1'b0);
    txData <= 1'b1;
    wr(ADR_LCR, 8'h43);
    settle(3);
    chk(txPin, 1'b0);
    settle(50);
    chk(txPin, 1'b0);
    wr(ADR_LCR, 8'h03);
    settle(3);
    chk(txPin, 1'b1);
    intSrc <= 4'hF;
    settle(4);
    chk(irqN, 1'b1);
    wr(ADR_IER, 8'h02);
    settle(3);
    chk(irqN, 1'b0);
    intSrc <= 4'h0;
    settle(3);
    chk(irqN, 1'b1);
    $display("test break send and irq done");
    // one 8n1 frame is 160 ticks at one tick per cycle
    usb_far_end_i.setLine(1'b0);
    settle(140);
    chk(breakDet, 1'b0);
    waitOn(breakDet, 1'b1, 100, n);
    usb_far_end_i.setLine(1'b1);
    waitOn(breakDet, 1'b0, 10, n);
    wr(ADR_IER, 8'h01);
    rxFifoEmpty <= 1'b0;
    settle(600);
    chk(timeoutIrq, 1'b0);
    waitOn(timeoutIrq, 1'b1, 100, n);
    settle(2);
    chk(irqN, 1'b0);
    stopCentre <= 1'b1;
    settle(1);
    stopCentre <= 1'b0;
    waitOn(timeoutIrq, 1'b0, 4, n);
    rd(ADR_DATA, 8'h00);
    chk(rdPulses, 1);
    rxFifoEmpty <= 1'b1;
    $display("test break detect and time-out done");
    txFifoEmpty <= 1'b0;
    wr(ADR_IER, 8'h10);
    settle(20);
    chk(uartClkEn, 1'b1);
    {intOtherPend, rxBusy, txShiftEmpty} <= 3'b110;
    txFifoEmpty <= 1'b1;
    settle(5);
    chk(uartClkEn, 1'b1);
    {intOtherPend, rxBusy, txShiftEmpty} <= 3'b001;
    waitOn(uartClkEn, 1'b0, 10, n);
    countTicks(50, n);
    chk(n, 0);
    usb_far_end_i.setLine(1'b0);
    waitOn(uartClkEn, 1'b1, 10, n);
    usb_far_end_i.setLine(1'b1);
    waitOn(uartClkEn, 1'b0, 20, n);
    usb_far_end_i.setModem(4'h5);
    waitOn(uartClkEn, 1'b1, 10, n);
    waitOn(uartClkEn, 1'b0, 20, n);
    wr(ADR_DATA, 8'h55);
    // the write fills the tx fifo, so the block must stay awake after it
    txFifoEmpty <= 1'b0;
    waitOn(uartClkEn, 1'b1, 10, n);
    chk(lastTx, 8'h55);
    rd(ADR_LCR, 8'h03);
    // sleep off before any further divisor write
    wr(ADR_IER, 8'h00);
    rd(ADR_IER, 8'h00);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : tb_usb_top
